// file: src/flrc_pkg.sv
// Package of register offsets, field positions, reset values and modes.
package flrc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] FLRC_ADDR_CFG   = 8'h07;
  localparam logic [7:0] FLRC_ADDR_FEAT  = 8'h08;
  localparam logic [7:0] FLRC_ADDR_CUR   = 8'h09;
  localparam logic [7:0] FLRC_ADDR_EN    = 8'h0A;
  localparam logic [7:0] FLRC_ADDR_FLAGS = 8'h0B;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] FLRC_CFG_RST  = 8'h78;
  localparam logic [7:0] FLRC_FEAT_RST = 8'hD2;
  localparam logic [7:0] FLRC_CUR_RST  = 8'h00;
  localparam logic [7:0] FLRC_EN_RST   = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int CFG_LEVEL   = 7;
  localparam int CFG_FPOL    = 6;
  localparam int CFG_LPOL    = 5;
  localparam int CFG_RPOL    = 4;
  localparam int CFG_RFTORCH = 3;
  localparam int CFG_INPUT_VOLTAGE_FLASH_MONITOR    = 2;
  localparam int CFG_THMON   = 1;
  localparam int CFG_INDEXT  = 0;
  localparam int EN_THERM    = 7;
  localparam int EN_RF       = 6;
  localparam int EN_FPIN     = 5;
  localparam int EN_LPIN     = 4;
  localparam int EN_PRECHG   = 3;
  localparam int EN_PASS     = 2;
  localparam int FLG_RF      = 7;
  localparam int FLG_TOUT    = 0;

  // ==========================================================================
  // Timing
  localparam int FLRC_CLK_HZ      = 20_000_000;
  localparam int FLRC_TOUT_STEP_MS = 100;
  localparam int FLRC_TOUT_STEP_CYC =
    FLRC_CLK_HZ / 1000 * FLRC_TOUT_STEP_MS;

  // ==========================================================================
  // Operating modes
  typedef enum logic [1:0] {
    FLRC_STANDBY   = 2'h0,
    FLRC_INDICATOR = 2'h1,
    FLRC_TORCH     = 2'h2,
    FLRC_FLASH     = 2'h3
  } flrc_mode_t;

  typedef enum logic [2:0] {
    FLRC_S_IDLE  = 3'h1,
    FLRC_S_ARMED = 3'h2,
    FLRC_S_FIRE  = 3'h4
  } flrc_fsm_t;

endpackage : flrc_pkg

// file: src/flrc_timer.sv
// Flash time-out counter in a programmable number of whole steps of fixed length.
`timescale 1ns/10ps
module flrc_timer #(
  parameter int STEP_CYC = 2_000_000
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] steps_code,
  // Status
  output logic            expired
);

  localparam int CW = $clog2(STEP_CYC + 1);

  initial begin
    if (STEP_CYC < 1) $error("STEP_CYC must be at least one");
  end

  logic [CW-1:0] cyc_r;
  logic [3:0]    step_r;

  // =========================================================================
  // Counting
  // One step beyond the code, since code zero already means one step.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_r  <= '0;
      step_r <= '0;
    end else if (!run) begin
      cyc_r  <= '0;
      step_r <= '0;
    end else if (!expired) begin
      if (cyc_r == CW'(STEP_CYC - 1)) begin
        cyc_r  <= '0;
        step_r <= step_r + 4'h1;
      end else begin
        cyc_r <= cyc_r + CW'(1);
      end
    end
  end

  assign expired = run && (step_r > {1'b0, steps_code});

endmodule : flrc_timer

// file: src/flrc_regs.sv
// Register bank and mode control of the LED flash driver.
// ============================================================================
`timescale 1ns/10ps
module flrc_regs
  import flrc_pkg::*;
#(
  parameter int TOUT_STEP_CYC = FLRC_TOUT_STEP_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Register port from the serial bus engine
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Trigger pins
  input  wire logic       flash_trig,
  input  wire logic       lamp_trig,
  input  wire logic       rf_burst,
  // Fault reports from the analogue side
  input  wire logic [6:0] fault_in,
  // LED control outputs
  output logic            led_on,
  output logic      [1:0] led_mode,
  output logic      [3:0] led_code,
  output logic            led_torch_level,
  output logic            indicator_external,
  output logic            input_voltage_flash_monitor,
  output logic            thermistor_enable,
  output logic            thermistor_mode,
  output logic      [1:0] current_limit,
  output logic      [2:0] flash_ramp,
  output logic            output_cap_precharge_enable,
  output logic            pass_only
);

  // The time-out needs at least one clock per step, and the control fields
  // must sit clear of the two mode bits, which the RF lock treats apart.
  initial begin
    if (TOUT_STEP_CYC < 1) $error("TOUT_STEP_CYC must be at least one");
    if (EN_PASS < 2 || EN_PRECHG < 2 || EN_LPIN < 2) begin
      $error("Enable fields overlap the mode field");
    end
    if (EN_FPIN < 2 || EN_RF < 2 || EN_THERM < 2) begin
      $error("Enable fields overlap the mode field");
    end
    if (EN_THERM > 7 || CFG_LEVEL > 7 || FLG_RF > 7) begin
      $error("Field position outside the byte");
    end
    if (FLRC_CUR_RST[7] || FLRC_EN_RST[1:0] != FLRC_STANDBY) begin
      $error("Reset values break the reserved bit or standby");
    end
  end

  // ==========================================================================
  // Register storage
  logic [7:0] cfg_r;
  logic [7:0] feat_r;
  logic [7:0] cur_r;
  logic [7:0] en_r;
  logic [7:0] flags_r;
  logic       pass_hold_r;
  logic       inhibit_r;
  flrc_fsm_t  fsm_r;
  logic       flash_act_r;
  logic       expired;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // Pin levels normalised to active high.
  logic fpin;
  logic lpin;
  logic rfpin;
  assign fpin  = flash_trig == cfg_r[CFG_FPOL];
  assign lpin  = lamp_trig  == cfg_r[CFG_LPOL];
  assign rfpin = rf_burst   == cfg_r[CFG_RPOL];

  // The RF pin counts only when its enable is set, so a disabled pin can
  // neither flag nor lock the mode field.
  logic rf_evt;
  assign rf_evt = rfpin && en_r[EN_RF];

  logic flags_rd;
  assign flags_rd = reg_rd && hit(reg_addr, FLRC_ADDR_FLAGS);

  logic [1:0] mode_f;
  assign mode_f = en_r[1:0];

  // ==========================================================================
  // Configuration, features and current registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r  <= FLRC_CFG_RST;
      feat_r <= FLRC_FEAT_RST;
      cur_r  <= FLRC_CUR_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, FLRC_ADDR_CFG)) begin
        cfg_r <= reg_wdata;
      end
      if (hit(reg_addr, FLRC_ADDR_FEAT)) begin
        feat_r <= reg_wdata;
      end
      if (hit(reg_addr, FLRC_ADDR_CUR)) begin
        cur_r <= {1'b0, reg_wdata[6:0]};
      end
    end
  end

  // ==========================================================================
  // Enable register; the mode field is frozen while the RF flag stands.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_r <= FLRC_EN_RST;
    end else if (reg_wr && hit(reg_addr, FLRC_ADDR_EN)) begin
      en_r[7:2] <= reg_wdata[7:2];
      if (!flags_r[FLG_RF]) begin
        en_r[1:0] <= reg_wdata[1:0];
      end
    end
  end

  // ==========================================================================
  // Flags: set wins over the clear by read.
  logic [7:0] flag_set;
  assign flag_set = {rf_evt, fault_in[6:1], expired};

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= '0;
    end else if (flags_rd) begin
      flags_r <= flag_set;
    end else begin
      flags_r <= flags_r | flag_set;
    end
  end

  // Faults on fault_in[4:1] inhibit the LED until the flags are read back.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      inhibit_r <= 1'b0;
    end else if (|fault_in[4:1]) begin
      inhibit_r <= 1'b1;
    end else if (flags_rd) begin
      inhibit_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Pass-only hold across an active LED mode
  // The hold follows the mode field, not led_on, so an inhibited or idle
  // flash still keeps pass-only until the host writes standby.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pass_hold_r <= 1'b0;
    end else if (mode_f == FLRC_STANDBY) begin
      pass_hold_r <= 1'b0;
    end else if (en_r[EN_PASS]) begin
      pass_hold_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Flash sequencing
  logic fpin_d_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fpin_d_r <= 1'b0;
    end else begin
      fpin_d_r <= fpin;
    end
  end

  logic flash_mode;
  logic fstart;
  assign flash_mode = mode_f == FLRC_FLASH && !inhibit_r;
  // Without the pin enable the write itself starts the flash.
  assign fstart = en_r[EN_FPIN] ? (fpin && !fpin_d_r) : 1'b1;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fsm_r <= FLRC_S_IDLE;
    end else if (!flash_mode) begin
      fsm_r <= FLRC_S_IDLE;
    end else begin
      unique case (fsm_r)
        FLRC_S_IDLE: begin
          fsm_r <= FLRC_S_ARMED;
        end
        FLRC_S_ARMED: begin
          if (fstart) begin
            fsm_r <= FLRC_S_FIRE;
          end
        end
        FLRC_S_FIRE: begin
          // Level mode ends on time-out or when the pin drops (pin enable set); edge mode on time-out only.
          if (expired) begin
            fsm_r <= FLRC_S_ARMED;
          end else if (cfg_r[CFG_LEVEL] && en_r[EN_FPIN] && !fpin) begin
            fsm_r <= FLRC_S_ARMED;
          end
        end
        default: begin
          fsm_r <= FLRC_S_IDLE;
        end
      endcase
    end
  end

  logic fire;
  assign fire = fsm_r == FLRC_S_FIRE;

  // A flash with no pin enable never returns to standby after time-out, since
  // the mode field is the host's; on expired the FSM drops to ARMED and fires again.
  flrc_timer #(
    .STEP_CYC   (TOUT_STEP_CYC)
  ) u_timer (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .run        (fire),
    .steps_code (feat_r[2:0]),
    .expired    (expired)
  );

  // ==========================================================================
  // LED drive outputs
  logic on_nxt;
  logic torch_lvl_nxt;
  always_comb begin
    on_nxt        = 1'b0;
    torch_lvl_nxt = 1'b0;
    if (!inhibit_r) begin
      unique case (mode_f)
        FLRC_STANDBY: begin
          on_nxt = 1'b0;
        end
        FLRC_INDICATOR: begin
          on_nxt = cfg_r[CFG_INDEXT] ? lpin : 1'b1;
        end
        FLRC_TORCH: begin
          on_nxt = en_r[EN_LPIN] ? lpin : 1'b1;
        end
        FLRC_FLASH: begin
          on_nxt = fire && !expired;
          if (fire && rf_evt) begin
            on_nxt        = cfg_r[CFG_RFTORCH];
            torch_lvl_nxt = cfg_r[CFG_RFTORCH];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      led_on          <= 1'b0;
      led_mode        <= FLRC_STANDBY;
      led_code        <= '0;
      led_torch_level <= 1'b0;
      flash_act_r     <= 1'b0;
    end else begin
      led_on          <= on_nxt;
      led_mode        <= mode_f;
      led_torch_level <= torch_lvl_nxt;
      flash_act_r     <= fire;
      if (mode_f == FLRC_FLASH && !torch_lvl_nxt) begin
        led_code <= cur_r[3:0];
      end else begin
        led_code <= {1'b0, cur_r[6:4]};
      end
    end
  end

  // ==========================================================================
  // Feature outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      indicator_external          <= 1'b0;
      input_voltage_flash_monitor <= 1'b0;
      thermistor_enable           <= 1'b0;
      thermistor_mode             <= 1'b0;
      current_limit               <= '0;
      flash_ramp                  <= '0;
      output_cap_precharge_enable <= 1'b0;
      pass_only                   <= 1'b0;
    end else begin
      indicator_external          <= cfg_r[CFG_INDEXT];
      input_voltage_flash_monitor <= cfg_r[CFG_INPUT_VOLTAGE_FLASH_MONITOR];
      thermistor_enable           <= en_r[EN_THERM];
      thermistor_mode             <= cfg_r[CFG_THMON] && en_r[EN_THERM];
      current_limit               <= feat_r[7:6];
      flash_ramp                  <= feat_r[5:3];
      output_cap_precharge_enable <= en_r[EN_PRECHG];
      pass_only                   <= en_r[EN_PASS] || pass_hold_r;
    end
  end

  // ==========================================================================
  // Read data
  // Reads are registered; a read of the flags clears them at the same edge,
  // so the host always sees the state from before the clear.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        FLRC_ADDR_CFG:   reg_rdata <= cfg_r;
        FLRC_ADDR_FEAT:  reg_rdata <= feat_r;
        FLRC_ADDR_CUR:   reg_rdata <= cur_r;
        FLRC_ADDR_EN:    reg_rdata <= en_r;
        FLRC_ADDR_FLAGS: reg_rdata <= flags_r;
        default:         reg_rdata <= '0;
      endcase
    end
  end

endmodule : flrc_regs

// file: tb/flrc_host.sv
// Host model that issues single-byte register accesses.
`timescale 1ns/10ps
module flrc_host (
  // Clock
  input  wire logic       ref_clk,
  // Register port toward the block
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Data is scrambled once the strobe drops so stale bytes are not reused.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : flrc_host

// file: tb/flrc_regs_sva.sv
// Checker for the register bank ports.
`timescale 1ns/10ps
module flrc_regs_sva
  import flrc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       led_on,
  input wire logic [1:0] led_mode,
  input wire logic       indicator_external,
  input wire logic       input_voltage_flash_monitor,
  input wire logic       thermistor_enable,
  input wire logic       thermistor_mode,
  input wire logic [1:0] current_limit,
  input wire logic [2:0] flash_ramp,
  input wire logic       output_cap_precharge_enable,
  input wire logic       pass_only
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire en_w = reg_wr && reg_addr == FLRC_ADDR_EN;
  wire bad_a = reg_addr < 8'h07 || reg_addr > 8'h0B;

  // ==========
  // Assertions
  rsvd_bit_a: assert property (reg_rd && reg_addr == FLRC_ADDR_CUR ##1
    !reg_rd |=> !reg_rdata[7]) else $error("reserved bit read high");
  unmapped_rd_a: assert property (reg_rd && bad_a ##1 !reg_rd
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  mode_src_a: assert property ($changed(led_mode) |-> $past(en_w, 2))
    else $error("mode changed without write");
  pass_src_a: assert property ($rose(pass_only) |->
    $past(en_w && reg_wdata[EN_PASS], 2)) else $error("pass rose alone");
  pass_hold_a: assert property ($fell(pass_only) |->
    led_mode == 2'h0 || $past(led_mode) == 2'h0)
    else $error("pass dropped outside standby");
  feat_copy_a: assert property (reg_wr && reg_addr == FLRC_ADDR_FEAT
    ##1 !reg_wr |=> {current_limit, flash_ramp} == $past(reg_wdata[7:3], 2))
    else $error("feature fields not copied");
  cfg_copy_a: assert property (reg_wr && reg_addr == FLRC_ADDR_CFG
    ##1 !reg_wr |=> indicator_external == $past(reg_wdata[CFG_INDEXT], 2) &&
    input_voltage_flash_monitor == $past(reg_wdata[CFG_INPUT_VOLTAGE_FLASH_MONITOR], 2))
    else $error("config fields not copied");
  prechg_copy_a: assert property (en_w ##1 !reg_wr |=>
    output_cap_precharge_enable == $past(reg_wdata[EN_PRECHG], 2))
    else $error("precharge not copied");
  therm_gate_a: assert property (thermistor_mode |-> thermistor_enable)
    else $error("thermistor mode without enable");
  cover property (led_on && led_mode == FLRC_TORCH);
  cover property (pass_only);
  cover property (reg_rd && reg_addr == FLRC_ADDR_FLAGS);
endmodule : flrc_regs_sva

// file: tb/tb.sv
// Self-checking bench for the flash LED register bank.
`timescale 1ns/10ps
module tb;
  import flrc_pkg::*;
  logic       ref_clk, arst_n, flash_trig, lamp_trig, rf_burst;
  logic       reg_wr, reg_rd, led_on, led_torch_level, pass_only;
  logic       indicator_external, input_voltage_flash_monitor;
  logic       thermistor_enable, thermistor_mode;
  logic       output_cap_precharge_enable, s1, s2;
  logic [6:0] fault_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] led_mode, current_limit;
  logic [3:0] led_code;
  logic [2:0] flash_ramp;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int         mismatches, samples_checked;

  flrc_regs #(.TOUT_STEP_CYC(10)) dut (.*);
  flrc_host host (.*);

  // ==========
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic cmp(input logic [7:0] got, input logic [7:0] e);
    samples_checked++;
    if (got !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : cmp
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic close_out;
    $display("mismatches=%0d samples_checked=%0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // Read data holds until the next read, so it is taken two cycles late.
  always @(negedge ref_clk) begin
    if (s2) cmp(reg_rdata, exp_q.pop_front());
    s2 = s1;
    s1 = (reg_rd === 1'b1);
  end

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #2_000_000;
    mismatches++;
    close_out();
  end

  // ==========
  // Scenarios
  initial begin
    {arst_n, flash_trig, lamp_trig, rf_burst, s1, s2} = 6'h00;
    fault_in = 7'h00;
    seed = 32'h6B326D89;
    tick(5);
    arst_n = 1'b1;
    rd(FLRC_ADDR_CFG, FLRC_CFG_RST);
    rd(FLRC_ADDR_FEAT, FLRC_FEAT_RST);
    rd(FLRC_ADDR_EN, FLRC_EN_RST);
    rd(8'h0C, 8'h00);
    cmp(8'({current_limit, flash_ramp}), 8'h1A);
    wr(FLRC_ADDR_CUR, 8'hFF);
    rd(FLRC_ADDR_CUR, 8'h7F);
    wr(FLRC_ADDR_EN, 8'h06);
    cmp(8'({led_on, led_mode, pass_only}), 8'h0D);
    wr(FLRC_ADDR_EN, 8'h02);
    cmp(8'(pass_only), 8'h01);
    wr(FLRC_ADDR_EN, 8'h01);
    cmp(8'({led_on, led_mode, pass_only}), 8'h0B);
    wr(FLRC_ADDR_EN, 8'h00);
    cmp(8'(pass_only), 8'h00);
    wr(FLRC_ADDR_EN, 8'h12);
    cmp(8'(led_on), 8'h00);
    lamp_trig = 1'b1;
    tick(3);
    cmp(8'(led_on), 8'h01);
    lamp_trig = 1'b0;
    wr(FLRC_ADDR_EN, 8'h00);
    wr(FLRC_ADDR_CFG, 8'h70);
    wr(FLRC_ADDR_EN, 8'h42);
    rf_burst = 1'b1;
    tick(1);
    rf_burst = 1'b0;
    tick(2);
    wr(FLRC_ADDR_EN, 8'h40);
    cmp(8'({led_on, led_mode}), 8'h06);
    wr(FLRC_ADDR_EN, 8'h02);
    rd(FLRC_ADDR_FLAGS, 8'h80);
    rd(FLRC_ADDR_FLAGS, 8'h00);
    wr(FLRC_ADDR_EN, 8'h00);
    cmp(8'(led_mode), 8'h00);
    wr(FLRC_ADDR_FEAT, 8'hC0);
    cmp(8'({current_limit, flash_ramp}), 8'h18);
    wr(FLRC_ADDR_CUR, 8'h05);
    wr(FLRC_ADDR_EN, 8'h23);
    cmp(8'(led_on), 8'h00);
    flash_trig = 1'b1;
    tick(3);
    cmp(8'({led_on, led_code}), 8'h15);
    tick(20);
    cmp(8'(led_on), 8'h00);
    flash_trig = 1'b0;
    rd(FLRC_ADDR_FLAGS, 8'h01);
    wr(FLRC_ADDR_EN, 8'h00);
    fault_in = 7'h04;
    tick(2);
    fault_in = 7'h00;
    rd(FLRC_ADDR_FLAGS, 8'h04);
    wr(FLRC_ADDR_CFG, 8'hF8);
    wr(FLRC_ADDR_EN, 8'h63);
    flash_trig = 1'b1;
    tick(3);
    rf_burst = 1'b1;
    tick(2);
    cmp(8'({led_on, led_torch_level, led_code}), 8'h30);
    rf_burst = 1'b0;
    flash_trig = 1'b0;
    tick(2);
    cmp(8'(led_on), 8'h00);
    rd(FLRC_ADDR_FLAGS, 8'h80);
    wr(FLRC_ADDR_EN, 8'h00);
    wr(FLRC_ADDR_EN, 8'h88);
    wr(FLRC_ADDR_CFG, 8'h7A);
    cmp(8'({thermistor_enable, thermistor_mode,
            output_cap_precharge_enable}), 8'h07);
    wr(FLRC_ADDR_EN, 8'h00);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(FLRC_ADDR_CUR, seed[7:0]);
      rd(FLRC_ADDR_CUR, {1'b0, seed[6:0]});
      wr(FLRC_ADDR_CFG, seed[15:8]);
      cmp(8'({thermistor_mode, input_voltage_flash_monitor,
              indicator_external}), {6'h00, seed[10], seed[8]});
    end
    tick(4);
    close_out();
  end
endmodule : tb

bind flrc_regs flrc_regs_sva chk (.*);
